// ---- hdl/ucd_pkg.sv ----
// Constants shared by the two-channel codec port DMA configuration block
// Contract
// - Two independent channels, each with its own register set at distinct addresses.
// - Each channel holds a 14-bit slot mask, 8 low bits and 6 high bits.
// - High mask bits 7:6 give bytes per slot, 00b one byte up to 11b four.
// - Control bit 7 enables the channel; while zero the channel moves nothing.
// - Control bit 6 selects handshake mode, which applies to bulk OUT only.
// - In handshake mode one packet is moved, then enable clears and an interrupt rises.
// - Without handshake mode bulk OUT packets flow on with no software action.
// - Control bit 3 gives direction: one for IN endpoint, zero for OUT.
// - Control bits 2:0 select endpoint 1 to 7; code 000b is illegal.
// - Control bits 5 and 4 are read-only and read as zero.
// - Buffered byte count is captured at each start-of-frame and held all frame.
// - The count is 16 bits; its high byte has its own read-only register.
`default_nettype none

package ucd_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int NUM_CHAN = 2;
    localparam logic [15:0] ADDR_CTL [NUM_CHAN] = '{16'hffe8, 16'hffee};
    localparam logic [15:0] ADDR_MASK_HI [NUM_CHAN] = '{16'hffe9, 16'hffef};
    localparam logic [15:0] ADDR_MASK_LO [NUM_CHAN] = '{16'hffea, 16'hfff0};
    localparam logic [15:0] ADDR_FILL_LO [NUM_CHAN] = '{16'hffeb, 16'hfff3};
    localparam logic [15:0] ADDR_FILL_HI [NUM_CHAN] = '{16'hffec, 16'hfff4};

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_HSK_BIT = 6;
    localparam int CTL_DIR_BIT = 3;
    localparam int CTL_EP_LSB = 0;
    localparam int CTL_EP_W = 3;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hcf;
    localparam int BPS_LSB = 6;
    localparam int MASK_HI_W = 6;
    localparam int NUM_SLOTS = 14;
    localparam int SLOT_IDX_W = 4;
    localparam int FILL_W = 16;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Slot hit test, shared by every channel
    function automatic logic slot_hit(input logic [NUM_SLOTS-1:0] mask,
                                      input logic [SLOT_IDX_W-1:0] idx);
        slot_hit = (32'(idx) < NUM_SLOTS) && mask[idx];
    endfunction : slot_hit

endpackage : ucd_pkg

`default_nettype wire

// ---- hdl/ucd_chan_if.sv ----
// Carrier between the register file and one channel's transfer logic
`default_nettype none

interface ucd_chan_if;
    logic [7:0] ctl;
    logic [ucd_pkg::NUM_SLOTS-1:0] mask;
    logic [ucd_pkg::FILL_W-1:0] fill_snap;
    logic hsk_done;
    logic slot_take;
    logic irq;

    modport regs (output ctl, output mask, input fill_snap, input hsk_done,
                  input slot_take, input irq);
    modport chan (input ctl, input mask, output fill_snap, output hsk_done,
                  output slot_take, output irq);
endinterface : ucd_chan_if

`default_nettype wire

// ---- hdl/ucd_chan.sv ----
// One channel: slot gating, handshake completion and frame count capture
`default_nettype none

module ucd_chan (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    ucd_chan_if.chan cfg,
    input wire logic sof_i,
    input wire logic [ucd_pkg::FILL_W-1:0] fill_bytes_i,
    input wire logic pkt_done_i,
    input wire logic slot_stb_i,
    input wire logic [ucd_pkg::SLOT_IDX_W-1:0] slot_idx_i
);

    logic enabled;
    logic xfer_ok;
    logic bulk_out_hsk;

    // ****************************************
    // Qualifiers
    // ****************************************
    assign enabled = cfg.ctl[ucd_pkg::CTL_ENABLE_BIT];
    // An illegal endpoint code keeps the channel idle rather than hitting the control pipe
    assign xfer_ok = enabled && (cfg.ctl[ucd_pkg::CTL_EP_LSB +: ucd_pkg::CTL_EP_W] != 3'h0);
    assign bulk_out_hsk = cfg.ctl[ucd_pkg::CTL_HSK_BIT] && !cfg.ctl[ucd_pkg::CTL_DIR_BIT];
    assign cfg.hsk_done = xfer_ok && bulk_out_hsk && pkt_done_i;

    // ****************************************
    // Slot gating
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg.slot_take <= 1'b0;
        end else begin
            cfg.slot_take <= slot_stb_i && xfer_ok && ucd_pkg::slot_hit(cfg.mask, slot_idx_i);
        end
    end

    // ****************************************
    // Completion interrupt
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg.irq <= 1'b0;
        end else begin
            cfg.irq <= cfg.hsk_done;
        end
    end

    // ****************************************
    // Frame count capture
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg.fill_snap <= '0;
        end else if (sof_i) begin
            cfg.fill_snap <= fill_bytes_i;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_done;
        cfg.hsk_done ##1 cfg.irq;
    endsequence

    property p_irq_after_done;
        cfg.hsk_done |-> s_done;
    endproperty
    a_irq_after_done: assert property (p_irq_after_done) else $error("No irq after packet");

    property p_idle_no_take;
        !xfer_ok |=> !cfg.slot_take;
    endproperty
    a_idle_no_take: assert property (p_idle_no_take) else $error("Idle channel took slot");

    property p_mask_gate;
        (slot_stb_i && !ucd_pkg::slot_hit(cfg.mask, slot_idx_i)) |=> !cfg.slot_take;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("Masked slot taken");

    property p_snap_load;
        sof_i |=> (cfg.fill_snap == $past(fill_bytes_i));
    endproperty
    a_snap_load: assert property (p_snap_load) else $error("Count not captured at SOF");

    property p_snap_hold;
        !sof_i |=> $stable(cfg.fill_snap);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("Count moved mid-frame");

    property p_no_hsk_no_irq;
        !bulk_out_hsk |=> !cfg.irq;
    endproperty
    a_no_hsk_no_irq: assert property (p_no_hsk_no_irq) else $error("Irq outside handshake");

endmodule : ucd_chan

`default_nettype wire

// ---- hdl/ucd_dma_cfg.sv ----
// Top of the two-channel DMA configuration block with its register file
`default_nettype none

module ucd_dma_cfg (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic sof_i,
    input wire logic [ucd_pkg::NUM_CHAN-1:0][ucd_pkg::FILL_W-1:0] fill_bytes_i,
    input wire logic [ucd_pkg::NUM_CHAN-1:0] pkt_done_i,
    input wire logic slot_stb_i,
    input wire logic [ucd_pkg::SLOT_IDX_W-1:0] slot_idx_i,
    output logic [ucd_pkg::NUM_CHAN-1:0] slot_take_o,
    output logic [ucd_pkg::NUM_CHAN-1:0][1:0] bytes_per_slot_o,
    output logic [ucd_pkg::NUM_CHAN-1:0] channel_enable_o,
    output logic [ucd_pkg::NUM_CHAN-1:0] per_packet_handshake_o,
    output logic [ucd_pkg::NUM_CHAN-1:0] endpoint_direction_o,
    output logic [ucd_pkg::NUM_CHAN-1:0][2:0] endpoint_select_o,
    output logic [ucd_pkg::NUM_CHAN-1:0] handshake_irq_o
);

    logic [7:0] ctl [ucd_pkg::NUM_CHAN];
    logic [7:0] mask_hi [ucd_pkg::NUM_CHAN];
    logic [7:0] mask_lo [ucd_pkg::NUM_CHAN];
    logic [7:0] next_rdata;
    logic hsk_done [ucd_pkg::NUM_CHAN];
    logic [ucd_pkg::FILL_W-1:0] fill_snap [ucd_pkg::NUM_CHAN];

    ucd_chan_if chan_bus [ucd_pkg::NUM_CHAN] ();

    // ****************************************
    // Channel instances
    // ****************************************
    for (genvar c = 0; c < ucd_pkg::NUM_CHAN; c++) begin : g_chan
        assign chan_bus[c].ctl = ctl[c];
        assign chan_bus[c].mask = {mask_hi[c][ucd_pkg::MASK_HI_W-1:0], mask_lo[c]};
        assign slot_take_o[c] = chan_bus[c].slot_take;
        assign handshake_irq_o[c] = chan_bus[c].irq;
        assign hsk_done[c] = chan_bus[c].hsk_done;
        assign fill_snap[c] = chan_bus[c].fill_snap;

        // Each channel owns separate transfer state and capture logic
        ucd_chan u_chan (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .cfg(chan_bus[c]),
            .sof_i(sof_i),
            .fill_bytes_i(fill_bytes_i[c]),
            .pkt_done_i(pkt_done_i[c]),
            .slot_stb_i(slot_stb_i),
            .slot_idx_i(slot_idx_i)
        );
    end

    // ****************************************
    // Control registers
    // ****************************************
    // A software write in the same cycle as a handshake completion wins, so a
    // re-enable issued early is never lost.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < ucd_pkg::NUM_CHAN; c++) begin
                ctl[c] <= ucd_pkg::REG_RESET;
            end
        end else begin
            for (int c = 0; c < ucd_pkg::NUM_CHAN; c++) begin
                if (wr_i && addr_i == ucd_pkg::ADDR_CTL[c]) begin
                    ctl[c] <= wdata_i & ucd_pkg::CTL_WRITE_MASK;
                end else if (hsk_done[c]) begin
                    ctl[c][ucd_pkg::CTL_ENABLE_BIT] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Slot mask registers
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < ucd_pkg::NUM_CHAN; c++) begin
                mask_hi[c] <= ucd_pkg::REG_RESET;
                mask_lo[c] <= ucd_pkg::REG_RESET;
            end
        end else begin
            for (int c = 0; c < ucd_pkg::NUM_CHAN; c++) begin
                if (wr_i && addr_i == ucd_pkg::ADDR_MASK_HI[c]) begin
                    mask_hi[c] <= wdata_i;
                end
                if (wr_i && addr_i == ucd_pkg::ADDR_MASK_LO[c]) begin
                    mask_lo[c] <= wdata_i;
                end
            end
        end
    end

    // ****************************************
    // Configuration outputs
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bytes_per_slot_o <= '0;
            channel_enable_o <= '0;
            per_packet_handshake_o <= '0;
            endpoint_direction_o <= '0;
            endpoint_select_o <= '0;
        end else begin
            for (int c = 0; c < ucd_pkg::NUM_CHAN; c++) begin
                bytes_per_slot_o[c] <= mask_hi[c][ucd_pkg::BPS_LSB +: 2];
                channel_enable_o[c] <= ctl[c][ucd_pkg::CTL_ENABLE_BIT];
                per_packet_handshake_o[c] <= ctl[c][ucd_pkg::CTL_HSK_BIT];
                endpoint_direction_o[c] <= ctl[c][ucd_pkg::CTL_DIR_BIT];
                endpoint_select_o[c] <= ctl[c][ucd_pkg::CTL_EP_LSB +: ucd_pkg::CTL_EP_W];
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        next_rdata = ucd_pkg::UNMAPPED_READ;
        for (int c = 0; c < ucd_pkg::NUM_CHAN; c++) begin
            if (addr_i == ucd_pkg::ADDR_CTL[c]) begin
                next_rdata = ctl[c];
            end
            if (addr_i == ucd_pkg::ADDR_MASK_HI[c]) begin
                next_rdata = mask_hi[c];
            end
            if (addr_i == ucd_pkg::ADDR_MASK_LO[c]) begin
                next_rdata = mask_lo[c];
            end
            if (addr_i == ucd_pkg::ADDR_FILL_LO[c]) begin
                next_rdata = fill_snap[c][7:0];
            end
            if (addr_i == ucd_pkg::ADDR_FILL_HI[c]) begin
                next_rdata = fill_snap[c][15:8];
            end
        end
    end

    // Read data is held until the next read, so a slow core may sample late
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= ucd_pkg::UNMAPPED_READ;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_hsk_end(int c);
        hsk_done[c] && !(wr_i && addr_i == ucd_pkg::ADDR_CTL[c]);
    endsequence

    property p_hsk_self_clear(int c);
        s_hsk_end(c) |=> !ctl[c][ucd_pkg::CTL_ENABLE_BIT] ##1 !channel_enable_o[c];
    endproperty
    a_hsk_self_clear0: assert property (p_hsk_self_clear(0)) else $error("Ch0 enable kept");
    a_hsk_self_clear1: assert property (p_hsk_self_clear(1)) else $error("Ch1 enable kept");

    property p_stream_keeps(int c);
        (ctl[c][ucd_pkg::CTL_ENABLE_BIT] && !ctl[c][ucd_pkg::CTL_HSK_BIT] && pkt_done_i[c]
            && !(wr_i && addr_i == ucd_pkg::ADDR_CTL[c])) |=> ctl[c][ucd_pkg::CTL_ENABLE_BIT];
    endproperty
    a_stream_keeps0: assert property (p_stream_keeps(0)) else $error("Ch0 stopped streaming");
    a_stream_keeps1: assert property (p_stream_keeps(1)) else $error("Ch1 stopped streaming");

    property p_reserved_zero;
        ctl[0][5:4] == 2'h0 && ctl[1][5:4] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set");

    property p_fill_read;
        (rd_i && addr_i == ucd_pkg::ADDR_FILL_HI[1]) |=>
            rdata_o == $past(fill_snap[1][15:8]);
    endproperty
    a_fill_read: assert property (p_fill_read) else $error("High count read wrong");

    property p_ctl_write;
        (wr_i && addr_i == ucd_pkg::ADDR_CTL[0]) |=> ##1
            endpoint_select_o[0] == $past(wdata_i[2:0], 2);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("Endpoint select not loaded");

    property p_ctl_read(int c);
        (rd_i && addr_i == ucd_pkg::ADDR_CTL[c]) |=> rdata_o == $past(ctl[c]);
    endproperty
    a_ctl_read0: assert property (p_ctl_read(0)) else $error("Ch0 control read wrong");
    a_ctl_read1: assert property (p_ctl_read(1)) else $error("Ch1 control read wrong");

    property p_mask_write(int c);
        (wr_i && addr_i == ucd_pkg::ADDR_MASK_LO[c]) |=>
            mask_lo[c] == $past(wdata_i);
    endproperty
    a_mask_write0: assert property (p_mask_write(0)) else $error("Ch0 mask not loaded");
    a_mask_write1: assert property (p_mask_write(1)) else $error("Ch1 mask not loaded");

    // Configuration copies trail their register by exactly one cycle
    property p_bps_follow(int c);
        bytes_per_slot_o[c] == $past(mask_hi[c][ucd_pkg::BPS_LSB +: 2]);
    endproperty
    a_bps_follow0: assert property (p_bps_follow(0)) else $error("Ch0 bytes copy");
    a_bps_follow1: assert property (p_bps_follow(1)) else $error("Ch1 bytes copy");

    property p_enable_follow(int c);
        channel_enable_o[c] == $past(ctl[c][ucd_pkg::CTL_ENABLE_BIT]);
    endproperty
    a_enable_follow0: assert property (p_enable_follow(0)) else $error("Ch0 enable copy");
    a_enable_follow1: assert property (p_enable_follow(1)) else $error("Ch1 enable copy");

    // Software must never disturb the captured count
    property p_fill_ro;
        (wr_i && addr_i == ucd_pkg::ADDR_FILL_LO[0] && !sof_i) |=> $stable(fill_snap[0]);
    endproperty
    a_fill_ro: assert property (p_fill_ro) else $error("Count written by software");

endmodule : ucd_dma_cfg

`default_nettype wire

// ---- tb/ucd_far_model.sv ----
// Behavioural buffer manager and codec port driving both channels
`default_nettype none

module ucd_far_model (
    input wire logic clk_sys_i,
    output logic sof_o,
    output logic [ucd_pkg::NUM_CHAN-1:0][ucd_pkg::FILL_W-1:0] fill_bytes_o,
    output logic [ucd_pkg::NUM_CHAN-1:0] pkt_done_o,
    output logic slot_stb_o,
    output logic [ucd_pkg::SLOT_IDX_W-1:0] slot_idx_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sof_o = 1'b0;
        fill_bytes_o = '0;
        pkt_done_o = '0;
        slot_stb_o = 1'b0;
        slot_idx_o = '0;
    end

    // Live count moves on right after the frame start, so a stale capture shows
    task automatic frame(input logic [15:0] f0, input logic [15:0] f1);
        @(negedge clk_sys_i);
        fill_bytes_o = {f1, f0};
        sof_o = 1'b1;
        @(negedge clk_sys_i);
        sof_o = 1'b0;
        fill_bytes_o = {~f1, ~f0};
    endtask : frame

    task automatic packet(input int ch);
        @(negedge clk_sys_i);
        pkt_done_o[ch] = 1'b1;
        @(negedge clk_sys_i);
        pkt_done_o = '0;
    endtask : packet

    // Slot number is scrambled once the strobe drops
    task automatic slot(input logic [3:0] idx);
        @(negedge clk_sys_i);
        slot_stb_o = 1'b1;
        slot_idx_o = idx;
        @(negedge clk_sys_i);
        slot_stb_o = 1'b0;
        slot_idx_o = ~idx;
    endtask : slot
endmodule : ucd_far_model

`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the two-channel DMA configuration block
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys_i, rst_n_i, wr_i, rd_i, sof, stb;
    logic [15:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [1:0][15:0] fill;
    logic [1:0] pkt, take, en, hsk, dir, irq;
    logic [1:0][1:0] bps;
    logic [1:0][2:0] ep;
    logic [3:0] idx;
    int failures, comparisons;

    ucd_far_model far (.clk_sys_i(clk_sys_i), .sof_o(sof), .fill_bytes_o(fill),
        .pkt_done_o(pkt), .slot_stb_o(stb), .slot_idx_o(idx));

    ucd_dma_cfg dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .sof_i(sof), .fill_bytes_i(fill),
        .pkt_done_i(pkt), .slot_stb_i(stb), .slot_idx_i(idx), .slot_take_o(take),
        .bytes_per_slot_o(bps), .channel_enable_o(en), .per_packet_handshake_o(hsk),
        .endpoint_direction_o(dir), .endpoint_select_o(ep), .handshake_irq_o(irq));

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge clk_sys_i);
        wr_i = 1'b0;
    endtask : wr

    task automatic rd(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk_sys_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge clk_sys_i);
        rd_i = 1'b0;
        chk(what, rdata_o, exp);
    endtask : rd

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        for (int c = 0; c < 2; c++) begin
            rd("ctl", ucd_pkg::ADDR_CTL[c], 8'h00);
            rd("mask_hi", ucd_pkg::ADDR_MASK_HI[c], 8'h00);
            rd("mask_lo", ucd_pkg::ADDR_MASK_LO[c], 8'h00);
            rd("fill_hi", ucd_pkg::ADDR_FILL_HI[c], 8'h00);
        end
        rd("unmapped", 16'hffed, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_fields(input int c);
        wr(ucd_pkg::ADDR_CTL[c], 8'hff);
        wr(ucd_pkg::ADDR_CTL[1-c], 8'h00);
        rd("ctl", ucd_pkg::ADDR_CTL[c], 8'hcf);
        chk("outs", {en[c], hsk[c], dir[c], ep[c]}, 16'h003f);
        wr(ucd_pkg::ADDR_CTL[c], 8'h05);
        @(negedge clk_sys_i);
        chk("outs", {en[c], hsk[c], dir[c], ep[c]}, 16'h0005);
        for (int b = 0; b < 4; b++) begin
            wr(ucd_pkg::ADDR_MASK_HI[c], {b[1:0], 6'h2a});
            @(negedge clk_sys_i);
            chk("bps", bps[c], 16'(b));
            rd("mask_hi", ucd_pkg::ADDR_MASK_HI[c], {b[1:0], 6'h2a});
        end
        wr(ucd_pkg::ADDR_FILL_LO[c], 8'h5a);
        rd("fill_lo", ucd_pkg::ADDR_FILL_LO[c], 8'h00);
        $display("test fields done");
    endtask : t_fields

    task automatic t_slots(input int c);
        wr(ucd_pkg::ADDR_CTL[1-c], 8'h00);
        wr(ucd_pkg::ADDR_MASK_LO[c], 8'h81);
        wr(ucd_pkg::ADDR_MASK_HI[c], 8'h20);
        wr(ucd_pkg::ADDR_CTL[c], 8'h81);
        @(negedge clk_sys_i);
        for (int i = 0; i < 16; i++) begin
            far.slot(4'(i));
            chk("take", take, 16'(i == 0 || i == 7 || i == 13) << c);
        end
        // Enabled on the illegal endpoint, then disabled on endpoint 1: both stay idle
        foreach (ep[k]) begin
            wr(ucd_pkg::ADDR_CTL[c], (k == 0) ? 8'h01 : 8'h80);
            @(negedge clk_sys_i);
            far.slot(4'h0);
            chk("take", take, 16'h0000);
        end
        $display("test slots done");
    endtask : t_slots

    task automatic t_hsk(input int c);
        for (int n = 0; n < 2; n++) begin
            wr(ucd_pkg::ADDR_CTL[c], 8'hc2);
            @(negedge clk_sys_i);
            far.packet(c);
            chk("irq", irq, 16'(1 << c));
            @(negedge clk_sys_i);
            chk("irq_en", {irq, en}, 16'h0000);
            rd("ctl", ucd_pkg::ADDR_CTL[c], 8'h42);
        end
        // Streaming and IN direction keep the enable through packets
        foreach (ep[k]) begin
            wr(ucd_pkg::ADDR_CTL[c], (k == 0) ? 8'h82 : 8'hca);
            far.packet(c);
            far.packet(c);
            chk("irq", irq, 16'h0000);
            rd("ctl", ucd_pkg::ADDR_CTL[c], (k == 0) ? 8'h82 : 8'hca);
        end
        $display("test handshake done");
    endtask : t_hsk

    task automatic t_fill(input logic [15:0] f0, input logic [15:0] f1);
        far.frame(f0, f1);
        for (int r = 0; r < 2; r++) begin
            rd("fill_lo0", ucd_pkg::ADDR_FILL_LO[0], f0[7:0]);
            rd("fill_hi0", ucd_pkg::ADDR_FILL_HI[0], f0[15:8]);
            rd("fill_lo1", ucd_pkg::ADDR_FILL_LO[1], f1[7:0]);
            rd("fill_hi1", ucd_pkg::ADDR_FILL_HI[1], f1[15:8]);
        end
        $display("test fill done");
    endtask : t_fill

    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // ****************************************
    // Clock, reset and sequence
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        final_report();
    end

    initial begin
        rst_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = '0;
        wdata_i = '0;
        repeat (10) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        t_reset();
        for (int c = 0; c < 2; c++) begin
            t_fields(c);
            t_slots(c);
            t_hsk(c);
        end
        t_fill(16'h1234, 16'hbeef);
        t_fill(16'h00ff, 16'h0100);
        final_report();
    end
endmodule : tb

`default_nettype wire
